// [hw/i2c_host_cfg.svh]
// register offsets, field positions and limits for the i2c host sequencer
`ifndef I2C_HOST_CFG_SVH
`define I2C_HOST_CFG_SVH

// device register map, reached as apb master
`define DEV_CTRL1_OFS 8'h00
`define DEV_CTRL2_OFS 8'h04
`define DEV_DATA_OFS 8'h10
`define DEV_STAT1_OFS 8'h14
`define DEV_STAT2_OFS 8'h18
`define DEV_CLKCTL_OFS 8'h1c
`define DEV_RISE_OFS 8'h20

// control_word_one bits
`define CW1_ENABLE_BIT 0
`define CW1_START_BIT 8
`define CW1_STOP_BIT 9
// control_word_two bits
`define CW2_EVT_IE_BIT 9
`define CW2_BUF_IE_BIT 10
// status_word_one bits
`define SW1_START_SENT_BIT 0
`define SW1_TARGET_ACKED_BIT 1
`define SW1_BYTE_DONE_BIT 2
`define SW1_HEADER_SENT_BIT 3
`define SW1_STOP_SEEN_BIT 4
`define SW1_TX_EMPTY_BIT 7
// status_word_two bits
`define SW2_MASTER_SEL_BIT 0
`define SW2_DIRECTION_BIT 2

// own command registers, apb slave
`define CMD_CTRL_OFS 8'h00
`define CMD_TARGET_OFS 8'h04
`define CMD_TIMING_OFS 8'h08
`define CMD_LEN_OFS 8'h0c
`define CMD_TXDATA_OFS 8'h10
`define CMD_STATUS_OFS 8'h14

// ten bit header prefix and peripheral clock limits in mhz
`define TEN_BIT_PREFIX 5'h1e
`define MIN_FREQ_STD_MHZ 6'h02
`define MIN_FREQ_FAST_MHZ 6'h04

`endif

// [hw/i2c_host_pkg.sv]
// types shared by the i2c host sequencer files
package i2c_host_pkg;

  typedef enum logic [17:0] {
    S_IDLE       = 18'h00001,
    S_CW2        = 18'h00002,
    S_CLKCTL     = 18'h00004,
    S_RISE       = 18'h00008,
    S_ENABLE     = 18'h00010,
    S_START      = 18'h00020,
    S_POLL_SB    = 18'h00040,
    S_ADDR1      = 18'h00080,
    S_POLL_HDR   = 18'h00100,
    S_ADDR2      = 18'h00200,
    S_POLL_ACK   = 18'h00400,
    S_READ_SW2   = 18'h00800,
    S_WAIT_DATA  = 18'h01000,
    S_WRITE_DATA = 18'h02000,
    S_POLL_TXE   = 18'h04000,
    S_STOP       = 18'h08000,
    S_POLL_MSL   = 18'h10000,
    S_CLR_STOP   = 18'h20000
  } seq_state_t;

  typedef struct packed {
    logic write;
    logic [7:0] addr;
    logic [31:0] wdata;
  } dev_op_t;

  typedef struct packed {
    logic ten_bit;
    logic rd;
    logic evt_ie;
    logic buf_ie;
    logic [9:0] target;
    logic [5:0] freq;
    logic [11:0] clkctl;
    logic [5:0] rise;
    logic fast;
    logic [7:0] len;
  } host_cfg_t;

endpackage

// [hw/apb_dev_master.sv]
// apb master engine that carries one device register access at a time
module apb_dev_master (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // request from the sequencer
  input wire logic op_req,
  input wire i2c_host_pkg::dev_op_t op,
  output logic op_done,
  output logic op_err,
  output logic [31:0] op_rdata,
  // apb master side
  output logic m_psel,
  output logic m_penable,
  output logic m_pwrite,
  output logic [7:0] m_paddr,
  output logic [31:0] m_pwdata,
  input wire logic [31:0] m_prdata,
  input wire logic m_pready,
  input wire logic m_pslverr
);
  logic psel_d, penable_d, done_d, err_d;
  logic [31:0] rdata_d;
  i2c_host_pkg::dev_op_t hold_q, hold_d;

  always_comb begin
    psel_d = m_psel;
    penable_d = m_penable;
    hold_d = hold_q;
    done_d = 1'b0;
    err_d = 1'b0;
    rdata_d = op_rdata;
    if (!m_psel) begin
      // one idle cycle after done so a stale request is not retaken
      if (op_req && !op_done) begin
        psel_d = 1'b1;
        hold_d = op;
      end
    end else if (!m_penable) begin
      penable_d = 1'b1;
    end else if (m_pready) begin
      psel_d = 1'b0;
      penable_d = 1'b0;
      done_d = 1'b1;
      err_d = m_pslverr;
      rdata_d = m_prdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      m_psel <= 1'b0;
      m_penable <= 1'b0;
      hold_q <= '0;
      op_done <= 1'b0;
      op_err <= 1'b0;
      op_rdata <= 32'h0;
    end else begin
      m_psel <= psel_d;
      m_penable <= penable_d;
      hold_q <= hold_d;
      op_done <= done_d;
      op_err <= err_d;
      op_rdata <= rdata_d;
    end
  end

  assign m_pwrite = hold_q.write;
  assign m_paddr = hold_q.addr;
  assign m_pwdata = hold_q.wdata;
endmodule

// [hw/apb_cmd_regs.sv]
// apb slave holding the host command, timing, data and status registers
`include "i2c_host_cfg.svh"
module apb_cmd_regs (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // towards the sequencer
  output i2c_host_pkg::host_cfg_t cfg,
  output logic go,
  output logic [7:0] tx_byte,
  output logic tx_valid,
  input wire logic tx_pop,
  input wire logic busy,
  input wire logic done_evt,
  input wire logic err_evt,
  input wire logic stop_evt,
  input wire logic dir,
  input wire logic [7:0] last_sw1
);
  i2c_host_pkg::host_cfg_t cfg_d;
  logic [7:0] tx_d;
  logic full_d, done_q, done_d, err_q, err_d, stop_q, stop_d;
  logic [31:0] rdata_d;
  logic wr, mapped;

  assign wr = psel && penable && pwrite;
  assign mapped = (paddr <= `CMD_STATUS_OFS) && (paddr[1:0] == 2'h0);
  assign pready = 1'b1;
  assign pslverr = psel && penable && (!mapped || (pwrite && paddr == `CMD_TXDATA_OFS
                   && tx_valid));
  assign go = wr && paddr == `CMD_CTRL_OFS && pwdata[0] && !busy;

  always_comb begin
    cfg_d = cfg;
    tx_d = tx_byte;
    full_d = tx_valid && !tx_pop;
    rdata_d = prdata;
    // hardware set wins over a software clear
    done_d = done_evt || done_q;
    err_d = err_evt || err_q;
    stop_d = stop_evt || stop_q;
    if (wr && !pslverr) begin
      case (paddr)
        `CMD_CTRL_OFS: begin
          cfg_d.ten_bit = pwdata[1];
          cfg_d.rd = pwdata[2];
          cfg_d.evt_ie = pwdata[3];
          cfg_d.buf_ie = pwdata[4];
        end
        `CMD_TARGET_OFS: cfg_d.target = pwdata[9:0];
        `CMD_TIMING_OFS: begin
          cfg_d.freq = pwdata[5:0];
          cfg_d.clkctl = pwdata[17:6];
          cfg_d.rise = pwdata[23:18];
          cfg_d.fast = pwdata[24];
        end
        `CMD_LEN_OFS: cfg_d.len = pwdata[7:0];
        `CMD_TXDATA_OFS: begin
          tx_d = pwdata[7:0];
          full_d = 1'b1;
        end
        `CMD_STATUS_OFS: begin
          done_d = done_evt || (done_q && !pwdata[0]);
          err_d = err_evt || (err_q && !pwdata[1]);
          stop_d = stop_evt || (stop_q && !pwdata[2]);
        end
        default: ;
      endcase
    end
    if (psel && !penable) begin
      case (paddr)
        `CMD_CTRL_OFS: rdata_d = {27'h0, cfg.buf_ie, cfg.evt_ie, cfg.rd, cfg.ten_bit, 1'b0};
        `CMD_TARGET_OFS: rdata_d = {22'h0, cfg.target};
        `CMD_TIMING_OFS: rdata_d = {7'h0, cfg.fast, cfg.rise, cfg.clkctl, cfg.freq};
        `CMD_LEN_OFS: rdata_d = {24'h0, cfg.len};
        `CMD_STATUS_OFS: rdata_d = {16'h0, last_sw1, 2'h0, dir, tx_valid, busy, stop_q,
                                    err_q, done_q};
        default: rdata_d = 32'h0;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg <= '0;
      tx_byte <= 8'h00;
      tx_valid <= 1'b0;
      done_q <= 1'b0;
      err_q <= 1'b0;
      stop_q <= 1'b0;
      prdata <= 32'h0;
    end else begin
      cfg <= cfg_d;
      tx_byte <= tx_d;
      tx_valid <= full_d;
      done_q <= done_d;
      err_q <= err_d;
      stop_q <= stop_d;
      prdata <= rdata_d;
    end
  end
endmodule

// [hw/i2c_master_transmit_sequencer.sv]
// host sequencer that drives a two-wire bus peripheral's registers for master transmit
//
// Added by the designer: the register offsets and the APB interface to the registers.
`include "i2c_host_cfg.svh"
module i2c_master_transmit_sequencer (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // command port, apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // device register port, apb master
  output logic dev_psel,
  output logic dev_penable,
  output logic dev_pwrite,
  output logic [7:0] dev_paddr,
  output logic [31:0] dev_pwdata,
  input wire logic [31:0] dev_prdata,
  input wire logic dev_pready,
  input wire logic dev_pslverr
);
  i2c_host_pkg::seq_state_t state_q, state_d, ret_q, ret_d;
  i2c_host_pkg::host_cfg_t cfg;
  i2c_host_pkg::dev_op_t op;
  logic op_req, op_done, op_err, go, tx_valid, tx_pop;
  logic [31:0] op_rdata;
  logic [7:0] tx_byte, count_q, count_d, sw1_q, sw1_d;
  logic restart_q, restart_d, dir_q, dir_d;
  logic done_evt, err_evt, stop_evt, busy, freq_ok;

  function automatic logic [7:0] header_byte(input logic [9:0] tgt, input logic rd);
    header_byte = {`TEN_BIT_PREFIX, tgt[9:8], rd};
  endfunction

  function automatic logic [31:0] cw1_word(input logic start, input logic stop);
    cw1_word = 32'h0;
    cw1_word[`CW1_ENABLE_BIT] = 1'b1;
    cw1_word[`CW1_START_BIT] = start;
    cw1_word[`CW1_STOP_BIT] = stop;
  endfunction

  apb_cmd_regs u_regs (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .cfg(cfg),
    .go(go),
    .tx_byte(tx_byte),
    .tx_valid(tx_valid),
    .tx_pop(tx_pop),
    .busy(busy),
    .done_evt(done_evt),
    .err_evt(err_evt),
    .stop_evt(stop_evt),
    .dir(dir_q),
    .last_sw1(sw1_q)
  );

  apb_dev_master u_master (
    .pclk(pclk),
    .presetn(presetn),
    .op_req(op_req),
    .op(op),
    .op_done(op_done),
    .op_err(op_err),
    .op_rdata(op_rdata),
    .m_psel(dev_psel),
    .m_penable(dev_penable),
    .m_pwrite(dev_pwrite),
    .m_paddr(dev_paddr),
    .m_pwdata(dev_pwdata),
    .m_prdata(dev_prdata),
    .m_pready(dev_pready),
    .m_pslverr(dev_pslverr)
  );

  assign busy = (state_q != i2c_host_pkg::S_IDLE);
  // peripheral clock must meet the speed minimum before a transfer is started
  assign freq_ok = cfg.fast ? (cfg.freq >= `MIN_FREQ_FAST_MHZ) :
                              (cfg.freq >= `MIN_FREQ_STD_MHZ);

  // device access issued in each state except S_IDLE and S_WAIT_DATA
  always_comb begin
    op_req = 1'b1;
    op = '0;
    case (state_q)
      i2c_host_pkg::S_CW2: begin
        op.write = 1'b1;
        op.addr = `DEV_CTRL2_OFS;
        op.wdata = {26'h0, cfg.freq};
        op.wdata[`CW2_EVT_IE_BIT] = cfg.evt_ie;
        op.wdata[`CW2_BUF_IE_BIT] = cfg.buf_ie;
      end
      i2c_host_pkg::S_CLKCTL: op = '{1'b1, `DEV_CLKCTL_OFS, {cfg.fast, 19'h0, cfg.clkctl}};
      i2c_host_pkg::S_RISE: op = '{1'b1, `DEV_RISE_OFS, {26'h0, cfg.rise}};
      i2c_host_pkg::S_ENABLE: op = '{1'b1, `DEV_CTRL1_OFS, cw1_word(1'b0, 1'b0)};
      i2c_host_pkg::S_START: op = '{1'b1, `DEV_CTRL1_OFS, cw1_word(1'b1, 1'b0)};
      i2c_host_pkg::S_ADDR1: begin
        op.write = 1'b1;
        op.addr = `DEV_DATA_OFS;
        if (cfg.ten_bit) begin
          op.wdata = {24'h0, header_byte(cfg.target, restart_q)};
        end else begin
          op.wdata = {24'h0, cfg.target[6:0], cfg.rd};
        end
      end
      i2c_host_pkg::S_ADDR2: op = '{1'b1, `DEV_DATA_OFS, {24'h0, cfg.target[7:0]}};
      i2c_host_pkg::S_WRITE_DATA: op = '{1'b1, `DEV_DATA_OFS, {24'h0, tx_byte}};
      i2c_host_pkg::S_STOP: op = '{1'b1, `DEV_CTRL1_OFS, cw1_word(1'b0, 1'b1)};
      i2c_host_pkg::S_CLR_STOP: op = '{1'b1, `DEV_CTRL1_OFS, cw1_word(1'b0, 1'b0)};
      i2c_host_pkg::S_POLL_SB, i2c_host_pkg::S_POLL_HDR, i2c_host_pkg::S_POLL_ACK,
      i2c_host_pkg::S_POLL_TXE: op = '{1'b0, `DEV_STAT1_OFS, 32'h0};
      i2c_host_pkg::S_READ_SW2, i2c_host_pkg::S_POLL_MSL: op = '{1'b0, `DEV_STAT2_OFS, 32'h0};
      default: op_req = 1'b0;
    endcase
  end

  // sequence through the master transmit flow
  always_comb begin
    state_d = state_q;
    ret_d = ret_q;
    count_d = count_q;
    restart_d = restart_q;
    dir_d = dir_q;
    sw1_d = sw1_q;
    done_evt = 1'b0;
    err_evt = 1'b0;
    stop_evt = 1'b0;
    tx_pop = 1'b0;
    if (state_q == i2c_host_pkg::S_IDLE) begin
      if (go) begin
        count_d = cfg.len;
        restart_d = 1'b0;
        err_evt = !freq_ok;
        state_d = freq_ok ? i2c_host_pkg::S_CW2 : i2c_host_pkg::S_IDLE;
      end
    end else if (state_q == i2c_host_pkg::S_WAIT_DATA) begin
      if (tx_valid) begin
        state_d = i2c_host_pkg::S_WRITE_DATA;
      end
    end else if (op_done && op_err) begin
      err_evt = 1'b1;
      state_d = i2c_host_pkg::S_IDLE;
    end else if (op_done && !op.write && op.addr == `DEV_STAT1_OFS
                 && op_rdata[`SW1_STOP_SEEN_BIT]) begin
      // a seen Stop is cleared by the control write that follows this read
      sw1_d = op_rdata[7:0];
      stop_evt = 1'b1;
      ret_d = state_q;
      state_d = i2c_host_pkg::S_CLR_STOP;
    end else if (op_done) begin
      if (!op.write && op.addr == `DEV_STAT1_OFS) begin
        sw1_d = op_rdata[7:0];
      end
      case (state_q)
        i2c_host_pkg::S_CW2: state_d = i2c_host_pkg::S_CLKCTL;
        i2c_host_pkg::S_CLKCTL: state_d = i2c_host_pkg::S_RISE;
        i2c_host_pkg::S_RISE: state_d = i2c_host_pkg::S_ENABLE;
        i2c_host_pkg::S_ENABLE: state_d = i2c_host_pkg::S_START;
        i2c_host_pkg::S_START: state_d = i2c_host_pkg::S_POLL_SB;
        i2c_host_pkg::S_POLL_SB: begin
          if (op_rdata[`SW1_START_SENT_BIT]) begin
            state_d = i2c_host_pkg::S_ADDR1;
          end
        end
        i2c_host_pkg::S_ADDR1: begin
          state_d = (cfg.ten_bit && !restart_q) ? i2c_host_pkg::S_POLL_HDR :
                    i2c_host_pkg::S_POLL_ACK;
        end
        i2c_host_pkg::S_POLL_HDR: begin
          if (op_rdata[`SW1_HEADER_SENT_BIT]) begin
            state_d = i2c_host_pkg::S_ADDR2;
          end
        end
        i2c_host_pkg::S_ADDR2: state_d = i2c_host_pkg::S_POLL_ACK;
        i2c_host_pkg::S_POLL_ACK: begin
          if (op_rdata[`SW1_TARGET_ACKED_BIT]) begin
            state_d = i2c_host_pkg::S_READ_SW2;
          end
        end
        i2c_host_pkg::S_READ_SW2: begin
          dir_d = op_rdata[`SW2_DIRECTION_BIT];
          if (cfg.rd && cfg.ten_bit && !restart_q) begin
            restart_d = 1'b1;
            state_d = i2c_host_pkg::S_START;
          end else if (cfg.rd || count_q == 8'h00) begin
            state_d = i2c_host_pkg::S_STOP;
          end else begin
            state_d = i2c_host_pkg::S_WAIT_DATA;
          end
        end
        i2c_host_pkg::S_WRITE_DATA: begin
          tx_pop = 1'b1;
          count_d = count_q - 8'h01;
          state_d = i2c_host_pkg::S_POLL_TXE;
        end
        i2c_host_pkg::S_POLL_TXE: begin
          // a status read here followed by the data write releases a held clock
          if (op_rdata[`SW1_TX_EMPTY_BIT] || op_rdata[`SW1_BYTE_DONE_BIT]) begin
            state_d = (count_q == 8'h00) ? i2c_host_pkg::S_STOP :
                      i2c_host_pkg::S_WAIT_DATA;
          end
        end
        i2c_host_pkg::S_STOP: state_d = i2c_host_pkg::S_POLL_MSL;
        i2c_host_pkg::S_POLL_MSL: begin
          if (!op_rdata[`SW2_MASTER_SEL_BIT]) begin
            done_evt = 1'b1;
            state_d = i2c_host_pkg::S_IDLE;
          end
        end
        i2c_host_pkg::S_CLR_STOP: state_d = ret_q;
        default: state_d = i2c_host_pkg::S_IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= i2c_host_pkg::S_IDLE;
      ret_q <= i2c_host_pkg::S_IDLE;
      count_q <= 8'h00;
      restart_q <= 1'b0;
      dir_q <= 1'b0;
      sw1_q <= 8'h00;
    end else begin
      state_q <= state_d;
      ret_q <= ret_d;
      count_q <= count_d;
      restart_q <= restart_d;
      dir_q <= dir_d;
      sw1_q <= sw1_d;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_START_AFTER_ENABLE: assert property (
    (state_q == i2c_host_pkg::S_START && $past(state_q) != i2c_host_pkg::S_START && !restart_q)
    |-> $past(state_q) == i2c_host_pkg::S_ENABLE)
    else $error("start issued before the enable write");
  AST_FREQ_REFUSED: assert property (
    (go && !freq_ok) |=> state_q == i2c_host_pkg::S_IDLE ##1 !dev_psel)
    else $error("transfer started with too slow a peripheral clock");
  AST_ADDR7_DIRECTION: assert property (
    (dev_psel && dev_pwrite && state_q == i2c_host_pkg::S_ADDR1 && !cfg.ten_bit)
    |-> dev_pwdata[0] == cfg.rd && dev_paddr == `DEV_DATA_OFS)
    else $error("seven bit address lsb does not match direction");
  AST_HEADER_FORM: assert property (
    (dev_psel && dev_penable && state_q == i2c_host_pkg::S_ADDR1 && cfg.ten_bit)
    |-> dev_pwdata[7:3] == `TEN_BIT_PREFIX && dev_pwdata[0] == restart_q
        && dev_pwdata[2:1] == cfg.target[9:8])
    else $error("ten bit header malformed");
  AST_STOP_WHEN_EMPTY: assert property (
    ($rose(state_q == i2c_host_pkg::S_STOP) && $past(state_q) == i2c_host_pkg::S_POLL_TXE)
    |-> (sw1_q[`SW1_TX_EMPTY_BIT] || sw1_q[`SW1_BYTE_DONE_BIT]) && count_q == 8'h00)
    else $error("stop requested without empty or byte done");
  AST_ADDR_AFTER_SB: assert property (
    $rose(state_q == i2c_host_pkg::S_ADDR1) |-> $past(state_q) == i2c_host_pkg::S_POLL_SB
    && sw1_q[`SW1_START_SENT_BIT])
    else $error("address written without start sent status read");
  AST_SECOND_BYTE: assert property (
    $rose(state_q == i2c_host_pkg::S_ADDR2) |-> $past(state_q) == i2c_host_pkg::S_POLL_HDR
    && sw1_q[`SW1_HEADER_SENT_BIT])
    else $error("second address byte without header sent read");
  AST_ACK_CLEAR: assert property (
    $rose(state_q == i2c_host_pkg::S_READ_SW2) |-> sw1_q[`SW1_TARGET_ACKED_BIT]
    ##[1:40] (dev_psel && !dev_pwrite && dev_paddr == `DEV_STAT2_OFS))
    else $error("acked flag not cleared by status two read");
  AST_STOP_FLAG_CLEAR: assert property (
    stop_evt |=> state_q == i2c_host_pkg::S_CLR_STOP
    ##[1:40] (dev_psel && dev_pwrite && dev_paddr == `DEV_CTRL1_OFS))
    else $error("stop flag not cleared by control word one write");
  AST_DATA_ONLY_WHEN_HELD: assert property (
    (dev_psel && dev_pwrite && dev_paddr == `DEV_DATA_OFS && state_q ==
     i2c_host_pkg::S_WRITE_DATA) |-> tx_valid && count_q != 8'h00)
    else $error("data write without a held byte");
endmodule

// [tb/dev_model.sv]
// behavioural register model of the two-wire bus peripheral
`include "i2c_host_cfg.svh"
module dev_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // scenario controls
  input wire logic slow,
  input wire logic stop_inj,
  input wire logic err_inj
);
  timeunit 1ns;
  timeprecision 1ps;
  logic start_sent_flag, target_acked_flag, header_sent_flag, stop_seen_flag;
  logic transmit_empty_flag, master_select_flag, direction_flag, sw1_read, wt;
  logic [31:0] rv, cw2_q;
  logic [7:0] wlog [16];
  logic [7:0] dlog [16];
  int nw, nd;
  wire xfer = psel & penable & pready;
  assign pready = psel & penable & (~slow | wt);
  assign pslverr = pready & err_inj;
  assign rv = (paddr == `DEV_STAT1_OFS) ? {24'h0, transmit_empty_flag, 2'h0, stop_seen_flag,
      header_sent_flag, 1'b0, target_acked_flag, start_sent_flag} :
      (paddr == `DEV_STAT2_OFS) ? {29'h0, direction_flag, 1'b0, master_select_flag} : 32'h0;
  // released bus shows the inverse, not a stale value
  assign prdata = psel ? rv : ~rv;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {start_sent_flag, target_acked_flag, header_sent_flag, stop_seen_flag} <= 4'h0;
      {transmit_empty_flag, master_select_flag, direction_flag, sw1_read, wt} <= 5'h0;
      nw <= 0;
      nd <= 0;
      cw2_q <= 32'h0;
    end else begin
      wt <= psel & penable & ~wt & slow;
      if (stop_inj) stop_seen_flag <= 1'b1;
      if (xfer & pwrite) begin
        wlog[nw[3:0]] <= paddr;
        nw <= nw + 1;
      end
      if (xfer & ~err_inj) begin
        sw1_read <= ~pwrite & paddr == `DEV_STAT1_OFS;
        if (~pwrite & paddr == `DEV_STAT2_OFS & sw1_read) target_acked_flag <= 1'b0;
        if (pwrite & paddr == `DEV_CTRL2_OFS) cw2_q <= pwdata;
        if (pwrite & paddr == `DEV_CTRL1_OFS) begin
          if (sw1_read) stop_seen_flag <= 1'b0;
          if (pwdata[`CW1_START_BIT]) begin
            start_sent_flag <= 1'b1;
            master_select_flag <= 1'b1;
          end
          if (pwdata[`CW1_STOP_BIT]) master_select_flag <= 1'b0;
        end
        if (pwrite & paddr == `DEV_DATA_OFS) begin
          dlog[nd[3:0]] <= pwdata[7:0];
          nd <= nd + 1;
          if (start_sent_flag & sw1_read) begin
            start_sent_flag <= 1'b0;
            direction_flag <= ~pwdata[0];
            if (pwdata[7:3] == `TEN_BIT_PREFIX & ~pwdata[0]) header_sent_flag <= 1'b1;
            else target_acked_flag <= 1'b1;
          end else if (header_sent_flag & sw1_read) begin
            header_sent_flag <= 1'b0;
            target_acked_flag <= 1'b1;
          end else transmit_empty_flag <= 1'b1;
        end
      end
    end
  end
endmodule

// [tb/i2c_master_transmit_sequencer_bench.sv]
// self-checking bench for the i2c host sequencer against the peripheral model
`include "i2c_host_cfg.svh"
module i2c_master_transmit_sequencer_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h0, dev_paddr;
  logic [31:0] pwdata = 32'h0, prdata, dev_pwdata, dev_prdata, rdat;
  logic pready, pslverr, dev_psel, dev_penable, dev_pwrite, dev_pready, dev_pslverr, serr;
  logic slow = 1'b0, stop_inj = 1'b0, err_inj = 1'b0;
  logic [7:0] order [5] = '{`DEV_CTRL2_OFS, `DEV_CLKCTL_OFS, `DEV_RISE_OFS,
      `DEV_CTRL1_OFS, `DEV_CTRL1_OFS};
  int fails = 0, checks = 0, n0;
  always #4 pclk = ~pclk;
  i2c_master_transmit_sequencer i2c_master_transmit_sequencer_inst (.pclk(pclk),
      .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .dev_psel(dev_psel), .dev_penable(dev_penable), .dev_pwrite(dev_pwrite),
      .dev_paddr(dev_paddr), .dev_pwdata(dev_pwdata), .dev_prdata(dev_prdata),
      .dev_pready(dev_pready), .dev_pslverr(dev_pslverr));
  dev_model dev_model_inst (.pclk(pclk), .presetn(presetn), .psel(dev_psel),
      .penable(dev_penable), .pwrite(dev_pwrite), .paddr(dev_paddr), .pwdata(dev_pwdata),
      .prdata(dev_prdata), .pready(dev_pready), .pslverr(dev_pslverr), .slow(slow),
      .stop_inj(stop_inj), .err_inj(err_inj));
  task automatic end_sim();
    if (fails == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    checks++;
    if (g !== x) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", n, x, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdat = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic xfer(input logic [31:0] c, input int n, input logic [7:0] b);
    apb(1'b1, `CMD_LEN_OFS, n);
    if (n > 0) begin
      apb(1'b1, `CMD_TXDATA_OFS, {24'h0, b});
      apb(1'b1, `CMD_TXDATA_OFS, {24'h0, b});
      chk("held", 32'h1, serr);
      apb(1'b0, `CMD_STATUS_OFS, 32'h0);
      chk("full", 32'h10, rdat & 32'h10);
    end
    apb(1'b1, `CMD_CTRL_OFS, c | 32'h1);
    for (int i = 1; i < n; i++) begin
      serr = 1'b1;
      while (serr) apb(1'b1, `CMD_TXDATA_OFS, {24'h0, b + 8'(i)});
    end
    do apb(1'b0, `CMD_STATUS_OFS, 32'h0); while (rdat[3]);
  endtask
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `CMD_STATUS_OFS, 32'h0);
    chk("status", 32'h0, rdat);
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped", 32'h1, {rdat[30:0], serr});
    apb(1'b1, `CMD_TIMING_OFS, 32'h00240a08);
    apb(1'b1, `CMD_TARGET_OFS, 32'h50);
    xfer(32'h18, 3, 8'h11);
    for (int i = 0; i < 5; i++) chk("order", order[i], dev_model_inst.wlog[i]);
    chk("addr7", 32'ha0, dev_model_inst.dlog[0]);
    for (int i = 1; i < 4; i++) chk("byte", 32'h10 + i, dev_model_inst.dlog[i]);
    chk("stop", `DEV_CTRL1_OFS, dev_model_inst.wlog[dev_model_inst.nw - 1]);
    chk("msl", 32'h0, dev_model_inst.master_select_flag);
    chk("done dir", 32'h21, rdat & 32'h23);
    chk("cw2", 32'h608, dev_model_inst.cw2_q);
    slow <= 1'b1;
    n0 = dev_model_inst.nd;
    apb(1'b1, `CMD_TARGET_OFS, 32'h2a5);
    fork
      xfer(32'h7, 0, 8'h0);
      begin
        repeat (40) @(posedge pclk);
        stop_inj <= 1'b1;
        @(posedge pclk);
        stop_inj <= 1'b0;
      end
    join
    chk("hdr", 32'hf4, dev_model_inst.dlog[n0]);
    chk("lo", 32'ha5, dev_model_inst.dlog[n0 + 1]);
    chk("hdr rd", 32'hf5, dev_model_inst.dlog[n0 + 2]);
    chk("rx stat", 32'h05, rdat & 32'h25);
    chk("dev stop", 32'h0, dev_model_inst.stop_seen_flag);
    apb(1'b1, `CMD_STATUS_OFS, 32'h4);
    apb(1'b0, `CMD_STATUS_OFS, 32'h0);
    chk("stop clr", 32'h0, rdat & 32'h4);
    xfer(32'h4, 0, 8'h0);
    chk("addr7 rd", 32'h4b, dev_model_inst.dlog[dev_model_inst.nd - 1]);
    chk("rx dir", 32'h01, rdat & 32'h23);
    slow <= 1'b0;
    for (int k = 0; k < 2; k++) begin
      apb(1'b1, `CMD_STATUS_OFS, 32'h2);
      apb(1'b1, `CMD_TIMING_OFS, (k != 0) ? 32'h01240a03 : 32'h00240a01);
      n0 = dev_model_inst.nw;
      xfer(32'h0, 0, 8'h0);
      chk("low freq", n0, dev_model_inst.nw);
      chk("err", 32'h2, rdat & 32'h2);
    end
    apb(1'b1, `CMD_TIMING_OFS, 32'h00240a08);
    apb(1'b1, `CMD_STATUS_OFS, 32'h2);
    err_inj <= 1'b1;
    n0 = dev_model_inst.nw;
    xfer(32'h0, 0, 8'h0);
    chk("abort", n0 + 1, dev_model_inst.nw);
    chk("abort err", 32'h2, rdat & 32'h2);
    end_sim();
  end
  initial begin
    repeat (20000) @(posedge pclk);
    fails++;
    end_sim();
  end
endmodule
